// ---- src/ssc_pkg.sv ----
package ssc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // conversion times per channel-count variant, in ns
  localparam int unsigned T_CONV8_NS = 4000;
  localparam int unsigned T_CONV6_NS = 3000;
  localparam int unsigned T_CONV4_NS = 2000;
  // range settling after a change on the range pin, in ns
  localparam int unsigned T_RANGE_SETTLE_NS = 80000;
  localparam int unsigned CONV8_CYCLES = T_CONV8_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV6_CYCLES = T_CONV6_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV4_CYCLES = T_CONV4_NS / CLK_PERIOD_NS;
  localparam int unsigned RANGE_SETTLE_CYCLES = (T_RANGE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned LSB_DIV = 65536;
  localparam int unsigned CNT_W = 16;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // lsb weight in 1/65536 V steps for the +/-10 V and +/-5 V spans
  localparam logic [RESULT_W-1:0] LSB_W_10V = 16'h0014;
  localparam logic [RESULT_W-1:0] LSB_W_5V = 16'h000a;
  // last count of the edges after reset release that follow the reference select
  localparam logic [1:0] REF_CAP_LAST = 2'h3;

  typedef enum logic [1:0] {
    SSC_IDLE = 2'b00,
    SSC_ARMED = 2'b01,
    SSC_CONV = 2'b11
  } ssc_state_t;

  // configuration: range tracked from the pin, reference captured after reset release
  typedef struct packed {
    logic range_10v;
    logic int_ref;
  } ssc_cfg_t;

  // conversion status seen by the controller
  typedef struct packed {
    logic busy;
    logic hold_first_set;
    logic hold_second_set;
  } ssc_status_t;
endpackage : ssc_pkg

// ---- src/ssc_sync_edge.sv ----
`timescale 1ns/10ps
// two-stage synchroniser with rising-edge detect on the second stage
module ssc_sync_edge
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pin side
  input wire logic async_i,
  // synchronised side
  output logic level_o,
  output logic rise_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
endmodule : ssc_sync_edge

// ---- src/ssc_conv_ctrl.sv ----
`timescale 1ns/10ps
// Summary of operation
// R1 - the range pin selects +/-10 V when high and +/-5 V when low for every channel.
// R2 - a range change acts at once, and a settling flag stays low for 80 us afterwards.
// R3 - the controller should keep the range pin at a fixed level rather than toggle it.
// R4 - the controller applies a reset after power-up so channels take the selected range.
// R5 - each set of track-and-holds goes into hold on the rising edge of its sample trigger.
// R6 - busy falls when all channels are converted, returning every track-and-hold to track.
// R7 - conversion is internally timed: 4 us for eight, 3 us for six, 2 us for four channels.
// R8 - previous results stay valid during busy and new ones replace them as busy falls.
// R9 - results are twos-complement with code transitions midway between integer LSB values.
// R10 - one LSB is the full-scale span over 65,536, so it follows the selected range.
// R11 - a high reference select enables the internal 2.5 V reference, low needs an external one.
// R12 - after reset the reference mode is that shown by the reference select input.
// R13 - busy rises on the sample trigger edge and stays high until conversion ends.
// R14 - with separate triggers, conversion starts after both edges, busy rising on the later.
// R15 - the controller issues no trigger while busy and waits acquisition time after it falls.
module ssc_conv_ctrl
#(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned RANGE_SETTLE = ssc_pkg::RANGE_SETTLE_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // sample triggers from the controller
  input wire logic sample_trigger_first_set_i,
  input wire logic sample_trigger_second_set_i,
  // static configuration pins
  input wire logic range_i,
  input wire logic ref_select_i,
  // raw signed codes from the converter core, one per channel
  input wire logic [NUM_CH*ssc_pkg::RESULT_W-1:0] core_code_i,
  // status and configuration
  output logic busy_o,
  output logic hold_first_set_o,
  output logic hold_second_set_o,
  output logic range_10v_o,
  output logic range_settled_o,
  output logic int_ref_en_o,
  output logic [ssc_pkg::RESULT_W-1:0] lsb_div_o,
  // result register
  output logic [NUM_CH*ssc_pkg::RESULT_W-1:0] result_o
);
  import ssc_pkg::*;

  localparam logic [CNT_W-1:0] CONV_LEN =
    (NUM_CH == 8) ? CONV8_CYCLES[CNT_W-1:0] :
    (NUM_CH == 6) ? CONV6_CYCLES[CNT_W-1:0] : CONV4_CYCLES[CNT_W-1:0];
  localparam int unsigned SET_W = 17;
  localparam logic [SET_W-1:0] SETTLE_LEN = RANGE_SETTLE[SET_W-1:0];
  localparam logic [SET_W-1:0] SET_ZERO = 17'h00000;
  localparam logic [SET_W-1:0] SET_ONE = 17'h00001;

  logic trig_a_lvl;
  logic trig_a_rise;
  logic trig_b_lvl;
  logic trig_b_rise;
  logic range_lvl;
  logic ref_lvl;

  // every trigger and configuration pin is asynchronous to clk_i, so each passes two flops first
  ssc_sync_edge u_sync_a
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(sample_trigger_first_set_i),
    .level_o(trig_a_lvl),
    .rise_o(trig_a_rise)
  );

  ssc_sync_edge u_sync_b
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(sample_trigger_second_set_i),
    .level_o(trig_b_lvl),
    .rise_o(trig_b_rise)
  );

  ssc_sync_edge u_sync_range
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(range_i),
    .level_o(range_lvl),
    .rise_o()
  );

  ssc_sync_edge u_sync_ref
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(ref_select_i),
    .level_o(ref_lvl),
    .rise_o()
  );

  // conversion sequencer state
  ssc_state_t state_q;
  ssc_state_t state_d;
  ssc_status_t stat_q;
  ssc_status_t stat_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic load_res;

  always_comb
  begin
    state_d = state_q;
    stat_d = stat_q;
    cnt_d = cnt_q;
    load_res = 1'b0;
    case (state_q)
      SSC_IDLE, SSC_ARMED:
      begin
        if (trig_a_rise)
        begin
          stat_d.hold_first_set = 1'b1; // [R5]
        end
        if (trig_b_rise)
        begin
          stat_d.hold_second_set = 1'b1; // [R5]
        end
        // start only once both sets are in hold [R14]
        if (stat_d.hold_first_set && stat_d.hold_second_set)
        begin
          state_d = SSC_CONV;
          stat_d.busy = 1'b1; // [R13]
          cnt_d = CONV_LEN; // [R7]
        end
        else if (stat_d.hold_first_set || stat_d.hold_second_set)
        begin
          state_d = SSC_ARMED;
        end
      end
      SSC_CONV:
      begin
        // trigger edges during busy are ignored by design [R15]
        if (cnt_q == CNT_ONE)
        begin
          state_d = SSC_IDLE;
          stat_d.busy = 1'b0; // [R6] [R13]
          stat_d.hold_first_set = 1'b0; // [R6]
          stat_d.hold_second_set = 1'b0;
          // old results held through busy, swapped as busy falls [R8]
          load_res = 1'b1;
          cnt_d = CNT_ZERO;
        end
        else
        begin
          cnt_d = cnt_q - CNT_ONE; // [R7]
        end
      end
      default:
      begin
        state_d = SSC_IDLE;
        stat_d = '0;
        cnt_d = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= SSC_IDLE;
      stat_q <= '0;
      cnt_q <= CNT_ZERO;
    end
    else
    begin
      state_q <= state_d;
      stat_q <= stat_d;
      cnt_q <= cnt_d;
    end
  end

  // one result word per channel, all swapped together as busy falls [R8]
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1)
    begin : g_res
      logic [RESULT_W-1:0] word_q;
      logic [RESULT_W-1:0] word_d;

      always_comb
      begin
        word_d = word_q;
        if (load_res)
        begin
          word_d = core_code_i[ch*RESULT_W +: RESULT_W]; // [R9]
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          word_q <= RESULT_RST;
        end
        else
        begin
          word_q <= word_d;
        end
      end

      assign result_o[ch*RESULT_W +: RESULT_W] = word_q;
    end
  endgenerate

  // configuration: range follows the pin, reference caught after reset
  ssc_cfg_t cfg_q;
  ssc_cfg_t cfg_d;
  logic [1:0] cap_cnt_q;
  logic [1:0] cap_cnt_d;
  logic [SET_W-1:0] settle_q;
  logic [SET_W-1:0] settle_d;
  logic [RESULT_W-1:0] lsb_q;
  logic [RESULT_W-1:0] lsb_d;

  // lsb weight in units of 1/65536 of 1 V: span 20 V or 10 V over 65,536
  function automatic logic [RESULT_W-1:0] lsb_units(input logic r10);
    lsb_units = r10 ? LSB_W_10V : LSB_W_5V; // [R10]
  endfunction : lsb_units

  always_comb
  begin
    cfg_d = cfg_q;
    cap_cnt_d = cap_cnt_q;
    settle_d = settle_q;
    // range acts at once; no latch needed [R1]
    cfg_d.range_10v = range_lvl; // [R1]
    // followed until the synchroniser has filled after reset, then frozen [R12]
    // its flops reset low, so the first two edges still see zero
    if (cap_cnt_q != REF_CAP_LAST)
    begin
      cfg_d.int_ref = ref_lvl; // [R11] [R12]
      cap_cnt_d = cap_cnt_q + 2'h1;
    end
    // a range change restarts the settling window; hard-wired range avoids it [R2] [R3]
    if (cfg_q.range_10v != range_lvl)
    begin
      settle_d = SETTLE_LEN; // [R2]
    end
    else if (settle_q != SET_ZERO)
    begin
      settle_d = settle_q - SET_ONE;
    end
    lsb_d = lsb_units(range_lvl); // [R10]
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q <= '0;
      cap_cnt_q <= '0;
      // stays unsettled for a full settling window after reset [R4]
      settle_q <= SETTLE_LEN;
      lsb_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      cap_cnt_q <= cap_cnt_d;
      settle_q <= settle_d;
      lsb_q <= lsb_d;
    end
  end

  logic settled_q;
  logic settled_d;

  always_comb
  begin
    settled_d = (settle_d == SET_ZERO);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      settled_q <= 1'b0;
    end
    else
    begin
      settled_q <= settled_d;
    end
  end

  assign busy_o = stat_q.busy;
  assign hold_first_set_o = stat_q.hold_first_set;
  assign hold_second_set_o = stat_q.hold_second_set;
  assign range_10v_o = cfg_q.range_10v;
  assign range_settled_o = settled_q;
  assign int_ref_en_o = cfg_q.int_ref;
  assign lsb_div_o = lsb_q;
endmodule : ssc_conv_ctrl

// ---- verification/ssc_conv_ctrl_monitor.sv ----
`timescale 1ns/10ps
module ssc_conv_monitor
  import ssc_pkg::*;
#(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned RANGE_SETTLE = 8000
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pins
  input wire logic sample_trigger_first_set_i,
  input wire logic [NUM_CH*ssc_pkg::RESULT_W-1:0] core_code_i,
  // outputs
  input wire logic busy_o,
  input wire logic hold_first_set_o,
  input wire logic hold_second_set_o,
  input wire logic range_10v_o,
  input wire logic range_settled_o,
  input wire logic int_ref_en_o,
  input wire logic [ssc_pkg::RESULT_W-1:0] lsb_div_o,
  input wire logic [NUM_CH*ssc_pkg::RESULT_W-1:0] result_o
);
  localparam int unsigned CONV = NUM_CH * 50;
  logic [15:0] bcnt_q;
  logic [15:0] bcnt_d;
  always_comb bcnt_d = busy_o ? bcnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) bcnt_q <= 16'h0000;
    else bcnt_q <= bcnt_d;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_end;
    $fell(busy_o);
  endsequence
  property p_conv_time; s_end |-> bcnt_q == CONV; endproperty
  property p_conv_max; busy_o |-> bcnt_q < CONV; endproperty
  property p_hold_busy; busy_o |-> hold_first_set_o && hold_second_set_o; endproperty
  property p_release; s_end |-> !hold_first_set_o && !hold_second_set_o; endproperty
  property p_later; $rose(busy_o) |-> $rose(hold_first_set_o) || $rose(hold_second_set_o); endproperty
  property p_result; s_end |-> result_o == $past(core_code_i); endproperty
  property p_keep; busy_o && $past(busy_o) |-> $stable(result_o); endproperty
  property p_hold_rise; $rose(sample_trigger_first_set_i) && !busy_o |-> ##[2:4] hold_first_set_o; endproperty
  property p_lsb;
    $stable(range_10v_o) && $past(reset_n_i, 2) |-> ##[0:1] lsb_div_o == (range_10v_o ? 16'h0014 : 16'h000a);
  endproperty
  property p_settle; $changed(range_10v_o) |=> !range_settled_o [*8]; endproperty
  property p_ref; $past(reset_n_i, 4) |-> $stable(int_ref_en_o); endproperty
  a_conv_time: assert property (p_conv_time) else $error("busy length wrong");
  a_conv_max: assert property (p_conv_max) else $error("busy too long");
  a_hold_busy: assert property (p_hold_busy) else $error("hold low in busy");
  a_release: assert property (p_release) else $error("hold after busy");
  a_later: assert property (p_later) else $error("busy not on hold edge");
  a_result: assert property (p_result) else $error("result wrong");
  a_keep: assert property (p_keep) else $error("result moved in busy");
  a_hold_rise: assert property (p_hold_rise) else $error("hold late");
  a_lsb: assert property (p_lsb) else $error("lsb weight wrong");
  a_settle: assert property (p_settle) else $error("settle flag high");
  a_ref: assert property (p_ref) else $error("ref mode moved");
endmodule : ssc_conv_monitor
bind ssc_conv_ctrl ssc_conv_monitor #(.NUM_CH(NUM_CH), .RANGE_SETTLE(RANGE_SETTLE)) u_mon
(
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .sample_trigger_first_set_i(sample_trigger_first_set_i),
  .core_code_i(core_code_i),
  .busy_o(busy_o),
  .hold_first_set_o(hold_first_set_o),
  .hold_second_set_o(hold_second_set_o),
  .range_10v_o(range_10v_o),
  .range_settled_o(range_settled_o),
  .int_ref_en_o(int_ref_en_o),
  .lsb_div_o(lsb_div_o),
  .result_o(result_o)
);

// ---- verification/ssc_host_model.sv ----
`timescale 1ns/10ps
module ssc_host_model
(
  // clock
  input wire logic clk_i,
  // requests
  input wire logic fire_a_i,
  input wire logic fire_b_i,
  // trigger pins
  output logic trig_a_o,
  output logic trig_b_o
);
  logic [2:0] a_q = 3'h0;
  logic [2:0] b_q = 3'h0;
  logic [2:0] a_d;
  logic [2:0] b_d;
  // wide enough for the two-flop synchroniser
  always_comb
  begin
    a_d = fire_a_i ? 3'h5 : a_q - {2'h0, a_q != 3'h0};
    b_d = fire_b_i ? 3'h5 : b_q - {2'h0, b_q != 3'h0};
  end
  always_ff @(posedge clk_i)
  begin
    a_q <= a_d;
    b_q <= b_d;
  end
  assign trig_a_o = a_q != 3'h0;
  assign trig_b_o = b_q != 3'h0;
endmodule : ssc_host_model

// ---- verification/ssc_conv_ctrl_tb_top.sv ----
`timescale 1ns/10ps
module ssc_conv_ctrl_tb_top;
  import ssc_pkg::*;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic range_i = 1'h1;
  logic ref_select_i = 1'h1;
  logic fire_a = 1'h0;
  logic fire_b = 1'h0;
  logic trig_a, trig_b, busy_o, hold_a, hold_b, range_10v, settled, int_ref;
  logic [15:0] lsb_div;
  logic [63:0] code_q = 64'h0;
  logic [63:0] result;
  logic [63:0] exp_q[$];
  logic busy_prev = 1'h0;
  logic [31:0] seed = 32'h768a;
  int err_total = 0;
  int samples_checked = 0;
  initial forever #5 clk_i = ~clk_i;
  ssc_host_model u_host (.clk_i(clk_i), .fire_a_i(fire_a), .fire_b_i(fire_b), .trig_a_o(trig_a), .trig_b_o(trig_b));
  ssc_conv_ctrl #(.NUM_CH(4), .RANGE_SETTLE(20)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .sample_trigger_first_set_i(trig_a), .sample_trigger_second_set_i(trig_b), .range_i(range_i),
    .ref_select_i(ref_select_i), .core_code_i(code_q), .busy_o(busy_o), .hold_first_set_o(hold_a),
    .hold_second_set_o(hold_b), .range_10v_o(range_10v), .range_settled_o(settled), .int_ref_en_o(int_ref),
    .lsb_div_o(lsb_div), .result_o(result));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy_o !== v && n < 600)
    begin
      @(posedge clk_i);
      n++;
    end
    if (busy_o !== v)
    begin
      err_total++;
      wrap_up();
    end
  endtask : wait_busy
  task automatic pulse(input logic a, input logic b);
    @(posedge clk_i);
    fire_a <= a;
    fire_b <= b;
    @(posedge clk_i);
    fire_a <= 1'h0;
    fire_b <= 1'h0;
  endtask : pulse
  // gap 0 is the common trigger; mid fires again while busy to be ignored
  task automatic conv(input int gap, input logic b_first, input logic mid);
    seed = lfsr(seed);
    code_q <= {seed, ~seed};
    exp_q.push_back({seed, ~seed});
    pulse(~b_first || gap == 0, b_first || gap == 0);
    if (gap > 0)
    begin
      repeat (gap) @(posedge clk_i);
      chk({busy_o, hold_a, hold_b}, {1'h0, ~b_first, b_first});
      pulse(b_first, ~b_first);
    end
    wait_busy(1'h1);
    if (mid)
    begin
      repeat (50) @(posedge clk_i);
      pulse(1'h1, 1'h1);
    end
    wait_busy(1'h0);
    repeat (20) @(posedge clk_i); // acquisition time
    chk(busy_o, 64'h0);
  endtask : conv
  always @(posedge clk_i)
  begin
    busy_prev <= busy_o;
    if (busy_prev === 1'h1 && busy_o === 1'h0)
      if (exp_q.size() == 0) chk(result, 64'hx);
      else chk(result, exp_q.pop_front());
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk({int_ref, range_10v, lsb_div}, {1'h1, 1'h1, 16'h0014});
    conv(0, 1'h0, 1'h0);
    conv(10, 1'h0, 1'h0);
    conv(10, 1'h1, 1'h1);
    @(posedge clk_i);
    range_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    chk({range_10v, settled, lsb_div}, {1'h0, 1'h0, 16'h000a});
    repeat (30) @(posedge clk_i);
    chk(settled, 64'h1);
    conv(0, 1'h0, 1'h0);
    ref_select_i <= 1'h0;
    reset_n_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk(int_ref, 64'h0);
    ref_select_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk(int_ref, 64'h0);
    wrap_up();
  end
endmodule : ssc_conv_ctrl_tb_top
